// file: rtl/cpid_pkg.sv
// Purpose: Shared constants and types for the command pulse input decoder.
// Assumes: 10 MHz system clock; command pulse rate at most 1.0 MHz.
// Notes: Increments are two-bit two's complement values.
package cpid_pkg;

    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned MAX_PULSE_HZ = 1_000_000;
    // Quadrature edges at full rate come a quarter period apart; the shortest gap rounds down.
    localparam int unsigned MIN_EDGE_CYC = CLK_HZ / (4 * MAX_PULSE_HZ);
    localparam int unsigned FILT_LEN_DEF = 2;

    localparam logic [1:0] FMT_RESET = 2'h1;
    localparam logic [1:0] DIR_RESET = 2'h0;
    localparam int unsigned DIR_CW_POS_BIT = 0;
    localparam int unsigned DIR_A_LEAD_BIT = 1;

    localparam logic [1:0] INC_ZERO = 2'h0;
    localparam logic [1:0] INC_POS = 2'h1;
    localparam logic [1:0] INC_NEG = 2'h3;

    typedef enum logic [1:0] {
        FMT_PULSE_SIGN = 2'b00,
        FMT_FWD_REV = 2'b01,
        FMT_QUAD = 2'b10
    } cpid_fmt_t;

    typedef struct packed {
        logic [1:0] fmt;
        logic [1:0] dir;
    } cpid_cfg_t;

endpackage

// file: rtl/cpid_decoder.sv
// Purpose: Decodes a command pulse train into signed position increments and makes encoder-style pulses.
// Assumes: Pin inputs are synchronous to I_CLK_SYS; settings are stable when reset is released.
// Notes: Settings are captured once after reset, which stands for power-up.
`timescale 1ns/1ps
module cpid_decoder #(
    parameter int unsigned FILT_LEN = cpid_pkg::FILT_LEN_DEF
) (
    input wire logic I_CLK_SYS,
    input wire logic I_RESET,
    input wire logic i_cmd_in_a_pos,
    input wire logic i_cmd_in_a_neg,
    input wire logic i_cmd_in_b_pos,
    input wire logic i_cmd_in_b_neg,
    input wire logic [1:0] i_format_sel,
    input wire logic [1:0] i_dir_sel,
    input wire logic i_position_mode,
    input wire logic i_fb_step,
    input wire logic i_fb_ccw,
    output logic o_cfg_ready,
    output logic [1:0] o_cmd_inc,
    output logic [1:0] o_motor_inc,
    output logic o_enc_a,
    output logic o_enc_b
);
    import cpid_pkg::*;

    // The filter must settle within the shortest legal gap between edges, so a longer filter is refused.
    if (FILT_LEN < 2 || FILT_LEN > MIN_EDGE_CYC) begin : g_bad_filt_len
        $error("FILT_LEN must lie between 2 and the shortest edge spacing");
    end

    cpid_cfg_t cfg_q;
    logic loaded_q;

    // Settings are taken once after reset release and then frozen.
    always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
        if (I_RESET) begin
            cfg_q <= '{fmt: FMT_RESET, dir: DIR_RESET};
            loaded_q <= 1'b0;
        end else if (!loaded_q) begin
            cfg_q <= '{fmt: i_format_sel, dir: i_dir_sel};
            loaded_q <= 1'b1;
        end
    end

    // A differential pair reads high when its positive leg is above its negative leg.
    wire [1:0] line_lvl = {i_cmd_in_b_pos & ~i_cmd_in_b_neg, i_cmd_in_a_pos & ~i_cmd_in_a_neg};
    logic [1:0] filt;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_chan
            logic sync1_q;
            logic sync2_q;
            logic [FILT_LEN-1:0] hist_q;
            logic filt_q;
            wire all_high = &hist_q;
            wire all_low = ~|hist_q;
            always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
                if (I_RESET) begin
                    sync1_q <= 1'b0;
                    sync2_q <= 1'b0;
                    hist_q <= '0;
                    filt_q <= 1'b0;
                end else begin
                    sync1_q <= line_lvl[gi];
                    sync2_q <= sync1_q;
                    hist_q <= {hist_q[FILT_LEN-2:0], sync2_q};
                    if (all_high) begin
                        filt_q <= 1'b1;
                    end else if (all_low) begin
                        filt_q <= 1'b0;
                    end
                end
            end
            assign filt[gi] = filt_q;
        end
    endgenerate

    logic [1:0] prev_q;
    wire a = filt[0];
    wire b = filt[1];
    wire pa = prev_q[0];
    wire pb = prev_q[1];
    wire rise_a = a & ~pa;
    wire rise_b = b & ~pb;
    wire chg_a = a ^ pa;
    wire chg_b = b ^ pb;
    // With B leading, the new B level differs from the old A level on every forward step.
    wire quad_fwd = pa ^ b;
    wire quad_one = chg_a ^ chg_b;

    logic [1:0] step;
    always_comb begin
        step = INC_ZERO;
        case (cfg_q.fmt)
            FMT_PULSE_SIGN: begin
                if (rise_a) begin
                    step = b ? INC_POS : INC_NEG;
                end
            end
            FMT_FWD_REV: begin
                if (rise_a && !rise_b) begin
                    step = INC_POS;
                end else if (rise_b && !rise_a) begin
                    step = INC_NEG;
                end
            end
            FMT_QUAD: begin
                // Both phases moving in one cycle is a glitch and is not counted.
                if (quad_one) begin
                    step = quad_fwd ? INC_POS : INC_NEG;
                end
            end
            default: begin
                step = INC_ZERO;
            end
        endcase
    end

    wire count_en = loaded_q & i_position_mode;
    wire [1:0] cmd_inc_d = count_en ? step : INC_ZERO;
    wire cw_pos = cfg_q.dir[DIR_CW_POS_BIT];
    // Motor increments are CCW positive, so a CW-positive setting flips the sign.
    wire [1:0] motor_inc_d = cw_pos ? (INC_ZERO - cmd_inc_d) : cmd_inc_d;

    logic [1:0] cmd_inc_q;
    logic [1:0] motor_inc_q;
    always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
        if (I_RESET) begin
            prev_q <= 2'h0;
            cmd_inc_q <= INC_ZERO;
            motor_inc_q <= INC_ZERO;
        end else begin
            prev_q <= filt;
            cmd_inc_q <= cmd_inc_d;
            motor_inc_q <= motor_inc_d;
        end
    end

    // Encoder-style output: a gray sequence whose low bit leads while counting up (CCW).
    logic [1:0] phase_q;
    wire [1:0] phase_d = i_fb_step ? (i_fb_ccw ? phase_q + 2'h1 : phase_q - 2'h1) : phase_q;
    wire [1:0] gray_d = {phase_d[1], phase_d[1] ^ phase_d[0]};
    wire a_lead = cfg_q.dir[DIR_A_LEAD_BIT];
    wire enc_a_d = a_lead ? gray_d[0] : gray_d[1];
    wire enc_b_d = a_lead ? gray_d[1] : gray_d[0];
    logic enc_a_q;
    logic enc_b_q;
    always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
        if (I_RESET) begin
            phase_q <= 2'h0;
            enc_a_q <= 1'b0;
            enc_b_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            enc_a_q <= enc_a_d;
            enc_b_q <= enc_b_d;
        end
    end

    assign o_cfg_ready = loaded_q;
    assign o_cmd_inc = cmd_inc_q;
    assign o_motor_inc = motor_inc_q;
    assign o_enc_a = enc_a_q;
    assign o_enc_b = enc_b_q;

    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RESET);

    sequence enc_ccw_step_s;
        i_fb_step && i_fb_ccw && loaded_q;
    endsequence

    sequence enc_cw_step_s;
        i_fb_step && !i_fb_ccw && loaded_q;
    endsequence

    mode_gate_a: assert property (!i_position_mode |=> o_cmd_inc == INC_ZERO)
        else $error("increment seen outside position control");
    pulse_sign_a: assert property (count_en && cfg_q.fmt == FMT_PULSE_SIGN && rise_a
        |=> o_cmd_inc == ($past(b) ? INC_POS : INC_NEG))
        else $error("pulse and sign decoded wrongly");
    fwd_rev_a: assert property (count_en && cfg_q.fmt == FMT_FWD_REV && (rise_a != rise_b)
        |=> o_cmd_inc == ($past(rise_a) ? INC_POS : INC_NEG))
        else $error("forward or reverse pulse decoded wrongly");
    quad_edge_a: assert property (count_en && cfg_q.fmt == FMT_QUAD && (chg_a != chg_b)
        |=> o_cmd_inc != INC_ZERO)
        else $error("quadrature edge not counted");
    quad_dir_a: assert property (count_en && cfg_q.fmt == FMT_QUAD && pa == pb && chg_b && !chg_a
        |=> o_cmd_inc == INC_POS)
        else $error("B leading A not counted positive");
    dir_map_a: assert property (o_cmd_inc != INC_ZERO
        |-> o_motor_inc == (cw_pos ? INC_ZERO - o_cmd_inc : o_cmd_inc))
        else $error("motor increment sign wrong");
    cfg_frozen_a: assert property (loaded_q |=> $stable(cfg_q) && loaded_q)
        else $error("settings changed after power-up");
    enc_lead_a: assert property (enc_ccw_step_s ##0 (o_enc_a == o_enc_b)
        |=> (a_lead ? (o_enc_a != $past(o_enc_a)) : (o_enc_b != $past(o_enc_b))))
        else $error("wrong phase leads during CCW rotation");
    enc_lag_a: assert property (enc_cw_step_s ##0 (o_enc_a == o_enc_b)
        |=> (a_lead ? (o_enc_b != $past(o_enc_b)) : (o_enc_a != $past(o_enc_a))))
        else $error("wrong phase leads during CW rotation");
    enc_one_step_a: assert property (i_fb_step && loaded_q
        |=> ((o_enc_a != $past(o_enc_a)) != (o_enc_b != $past(o_enc_b))))
        else $error("encoder step did not move exactly one phase");
    fwd_rev_both_a: assert property (count_en && cfg_q.fmt == FMT_FWD_REV && rise_a && rise_b
        |=> o_cmd_inc == INC_ZERO)
        else $error("simultaneous forward and reverse pulses counted");

endmodule

// file: verification/cpid_ctrl_model.sv
// Purpose: Behavioural positioning controller that drives both command pulse pairs.
// Assumes: Line levels change at the falling clock edge.
// Notes: Each pair is driven differentially; the negative leg is the inverse.
`timescale 1ns/1ps
module cpid_ctrl_model (
    input wire logic clk,
    output logic o_a_pos,
    output logic o_a_neg,
    output logic o_b_pos,
    output logic o_b_neg
);
    logic line_a = 1'b0;
    logic line_b = 1'b0;
    assign o_a_pos = line_a;
    assign o_a_neg = ~line_a;
    assign o_b_pos = line_b;
    assign o_b_neg = ~line_b;
    // Callers hold each level for n cycles; five per half period keeps the rate at the limit.
    task automatic drive(input logic a, input logic b, input int n);
        @(negedge clk);
        line_a = a;
        line_b = b;
        repeat (n - 1) @(negedge clk);
    endtask
endmodule

// file: verification/command_pulse_input_decoder_tb.sv
// Purpose: Self-checking bench for the command pulse input decoder.
// Assumes: 10 MHz clock; inputs change at the falling edge.
// Notes: Increments are summed every cycle so latency does not matter to the checks.
`timescale 1ns/1ps
module command_pulse_input_decoder_tb;
    import cpid_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] fmt = 2'h1;
    logic [1:0] dir = 2'h0;
    logic pmode = 1'b1;
    logic fb_step = 1'b0;
    logic fb_ccw = 1'b0;
    logic ap, an, bp, bn, rdy, enc_a, enc_b;
    logic [1:0] cinc, minc;
    int errors = 0;
    int samples_checked = 0;
    int cs = 0;
    int ms = 0;
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
    $display("BAD %s expected %0d seen %0d", n, e, g); end end
    always #50 clk = ~clk;
    cpid_ctrl_model gen (.clk(clk), .o_a_pos(ap), .o_a_neg(an), .o_b_pos(bp), .o_b_neg(bn));
    cpid_decoder dut (.I_CLK_SYS(clk), .I_RESET(rst), .i_cmd_in_a_pos(ap), .i_cmd_in_a_neg(an),
        .i_cmd_in_b_pos(bp), .i_cmd_in_b_neg(bn), .i_format_sel(fmt), .i_dir_sel(dir),
        .i_position_mode(pmode), .i_fb_step(fb_step), .i_fb_ccw(fb_ccw), .o_cfg_ready(rdy),
        .o_cmd_inc(cinc), .o_motor_inc(minc), .o_enc_a(enc_a), .o_enc_b(enc_b));
    always @(posedge clk) begin
        cs += (cinc === INC_POS) - (cinc === INC_NEG);
        ms += (minc === INC_POS) - (minc === INC_NEG);
    end
    task automatic restart(input logic [1:0] f, input logic [1:0] d);
        @(negedge clk);
        rst = 1'b1;
        fmt = f;
        dir = d;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        `CHK("cfg_ready", 1'b1, rdy)
        cs = 0;
        ms = 0;
    endtask
    task automatic pul(input logic ha, input logic hb, input logic la, input logic lb, input int cnt);
        repeat (cnt) begin
            gen.drive(ha, hb, 5);
            gen.drive(la, lb, 5);
        end
    endtask
    task automatic sums(input string n, input int ec, input int em);
        repeat (10) @(negedge clk);
        `CHK(n, ec, cs)
        `CHK(n, em, ms)
        cs = 0;
        ms = 0;
    endtask
    task automatic t_fwd_rev;
        restart(2'h1, 2'h0);
        pul(1'b1, 1'b0, 1'b0, 1'b0, 3);
        sums("forward", 3, 3);
        pul(1'b0, 1'b1, 1'b0, 1'b0, 2);
        sums("reverse", -2, -2);
        pul(1'b1, 1'b1, 1'b0, 1'b0, 1);
        sums("both_rise", 0, 0);
    endtask
    task automatic t_sign;
        restart(2'h0, 2'h1);
        gen.drive(1'b0, 1'b1, 5);
        pul(1'b1, 1'b1, 1'b0, 1'b1, 2);
        sums("sign_high", 2, -2);
        gen.drive(1'b0, 1'b0, 5);
        pul(1'b1, 1'b0, 1'b0, 1'b0, 1);
        sums("sign_low", -1, 1);
    endtask
    task automatic t_quad;
        restart(2'h2, 2'h3);
        gen.drive(1'b0, 1'b1, 3);
        gen.drive(1'b1, 1'b1, 3);
        gen.drive(1'b1, 1'b0, 3);
        gen.drive(1'b0, 1'b0, 3);
        sums("quad_b_lead", 4, -4);
        gen.drive(1'b1, 1'b0, 3);
        gen.drive(1'b1, 1'b1, 3);
        gen.drive(1'b0, 1'b1, 3);
        gen.drive(1'b0, 1'b0, 3);
        sums("quad_a_lead", -4, 4);
    endtask
    task automatic t_mode_latch;
        restart(2'h1, 2'h0);
        pmode = 1'b0;
        pul(1'b1, 1'b0, 1'b0, 1'b0, 2);
        sums("speed_mode", 0, 0);
        pmode = 1'b1;
        fmt = 2'h3;
        dir = 2'h1;
        pul(1'b1, 1'b0, 1'b0, 1'b0, 1);
        sums("latched_cfg", 1, 1);
        restart(2'h3, 2'h0);
        pul(1'b1, 1'b0, 1'b0, 1'b0, 1);
        pul(1'b0, 1'b1, 1'b0, 1'b0, 1);
        sums("fmt3_idle", 0, 0);
    endtask
    task automatic t_enc(input logic [1:0] d);
        restart(2'h1, d);
        fb_ccw = 1'b1;
        fb_step = 1'b1;
        @(negedge clk);
        fb_step = 1'b0;
        @(negedge clk);
        `CHK("enc_a", d[1], enc_a)
        `CHK("enc_b", ~d[1], enc_b)
        fb_ccw = 1'b0;
        fb_step = 1'b1;
        repeat (2) @(negedge clk);
        fb_step = 1'b0;
        @(negedge clk);
        `CHK("enc_a_cw", ~d[1], enc_a)
        `CHK("enc_b_cw", d[1], enc_b)
    endtask
    task automatic test_done;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #2ms;
        errors++;
        test_done();
    end
    initial begin
        t_fwd_rev();
        t_sign();
        t_quad();
        t_mode_latch();
        t_enc(2'h0);
        t_enc(2'h2);
        test_done();
    end
endmodule
